// File: pdb_bridge_cfg.sv
// PCIe bridge configuration, window decode, translation and option
// outputs. Assumes one clock, a plain register port and synchronous
// request inputs from the link side.
//
// How it works
// - Lite address bit 28 low: bridge registers
// - Lite address bit 28 high: DMA registers
// - DMA offset 0x2000 selects interrupt registers
// - Endpoint: six 32-bit or three 64-bit windows
// - Root port: two 32-bit or one 64-bit
// - Odd window consumed by 64-bit even window
// - Windows decode memory only, never I/O
// - Prefetchable reported only for 64-bit windows
// - Size 4K-2G at 32, 4K-256G at 64
// - Hit address translated to AXI base
// - Tags 32, or 64/256 with extension
// - Per-channel bypass mask, bit 0 channel 0
// - Read and write channels 1 to 4
// - Outstanding: read 2-64, write 2-32
// - Parity check on reads, generate on writes
// - Parity propagation passes parity to user
// - Completion timeout 50 ms or 50 us
// - Up to 16 user interrupt requests
// - MSI default on, 1 vector, up to 32
// - Exactly one legacy interrupt pin
// - AXI ID width 4 or 2 bits
// - Link reset source holds DMA while down
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module pdb_bridge_cfg #(
    parameter int DW = 32,
    parameter longint CTO_LONG_CYC = pdb_pkg::CTO_LONG_NS / pdb_pkg::CLK_NS
) (
    input wire logic clk_sys_in, // System clock
    input wire logic rst_in, // Sync reset, high
    input wire logic [pdb_pkg::RA_W-1:0] reg_addr_in, // Reg address
    input wire logic [31:0] reg_wdata_in, // Reg write data
    input wire logic reg_wr_in, // Reg write strobe
    input wire logic reg_rd_in, // Reg read strobe
    output logic [31:0] reg_rdata_out, // Reg read data
    input wire logic lite_valid_in, // Lite access present
    input wire logic [31:0] lite_addr_in, // Lite address
    output logic lite_sel_bridge_out, // To bridge registers
    output logic lite_sel_dma_out, // To DMA registers
    output logic lite_sel_intr_out, // To interrupt registers
    input wire logic req_valid_in, // PCIe request
    input wire logic [pdb_pkg::AW-1:0] req_addr_in, // PCIe address
    output logic axi_valid_out, // Translated request
    output logic [pdb_pkg::AW-1:0] axi_addr_out, // AXI address
    output logic [2:0] axi_win_out, // Hit window
    output logic miss_out, // Request dropped
    input wire logic link_up_in, // PCIe link up
    output logic dma_rst_out, // DMA reset
    input wire logic [DW-1:0] rd_data_in, // Data read from PCIe
    input wire logic [DW/8-1:0] rd_par_in, // Its parity
    input wire logic [DW-1:0] wr_data_in, // Data toward PCIe
    input wire logic [DW/8-1:0] usr_wr_par_in, // User parity
    output logic [DW/8-1:0] wr_par_out, // Parity toward PCIe
    output logic [DW/8-1:0] usr_rd_par_out, // Parity to user
    output logic par_err_out, // Read parity error
    output logic [8:0] num_tags_out, // Request tags
    output logic [2:0] rd_chan_out, // Read channels
    output logic [2:0] wr_chan_out, // Write channels
    output logic [6:0] rd_outst_out, // Read outstanding
    output logic [6:0] wr_outst_out, // Write outstanding
    output logic [3:0] rd_bypass_out, // Read bypass mask
    output logic [3:0] wr_bypass_out, // Write bypass mask
    output logic [31:0] cto_cycles_out, // Timeout cycles
    output logic [4:0] uirq_cnt_out, // User irq count
    output logic msi_en_out, // MSI enabled
    output logic [5:0] msi_vec_out, // MSI vectors
    output logic [3:0] intx_pin_out, // Legacy pin one-hot
    output logic [2:0] axi_id_w_out // AXI ID width
);
    import pdb_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] clamp(logic [7:0] v, logic [7:0] lo,
                                         logic [7:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic [DW/8-1:0] byte_par(logic [DW-1:0] d);
        for (int b = 0; b < DW / 8; b++) begin
            byte_par[b] = ^d[b*8 +: 8];
        end
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] cfg0;
    logic [31:0] cfg1;
    logic [31:0] wctrl [NWIN];
    logic [AW-1:0] wbase [NWIN];
    logic [AW-1:0] wxlat [NWIN];
    logic [2:0] last_win;
    logic last_miss;

    // Configuration fields
    wire bridge_mode = cfg0[0];
    wire root_port = cfg0[1];
    wire ext_tag = cfg0[2];
    wire fam_new = cfg0[3];
    wire par_chk = cfg0[4];
    wire par_prop = cfg0[5];
    wire cto_short = cfg0[6];
    wire id_narrow = cfg0[7];
    wire rst_phy = cfg0[8];

    // Register port decode
    wire [2:0] rwidx = reg_addr_in[7:5];
    wire [2:0] rword = reg_addr_in[4:2];
    wire rwin = reg_addr_in[11:8] == WIN_PAGE && rwidx < 3'(NWIN);

    // Effective window view
    logic [NWIN-1:0] eff_en;
    logic [NWIN-1:0] eff64;
    logic [NWIN-1:0] eff_pf;
    logic [NWIN-1:0] hit;
    logic [7:0] eff_sz [NWIN];
    logic [AW-1:0] wmask [NWIN];
    logic [AW-1:0] bbase [NWIN];

    // Window attributes, size clamp and aligned hit compare
    always_comb begin
        for (int i = 0; i < NWIN; i++) begin
            eff64[i] = (i % 2 == 0) && wctrl[i][1];
            eff_en[i] = wctrl[i][0] && !(root_port && i > 1);
            if (i % 2 == 1) begin
                eff_en[i] = eff_en[i] && !eff64[i-1];
            end
            eff_pf[i] = wctrl[i][2] && eff64[i];
            eff_sz[i] = clamp({2'b00, wctrl[i][8:3]}, SZ_MIN,
                              eff64[i] ? SZ_MAX64 : SZ_MAX32);
            wmask[i] = ~((AW'(1) << eff_sz[i]) - AW'(1));
            bbase[i] = eff64[i] ? wbase[i] : {32'h0000_0000,
                                              wbase[i][31:0]};
            hit[i] = eff_en[i] &&
                     ((req_addr_in ^ bbase[i]) & wmask[i]) == '0;
        end
    end

    // Lowest hitting window wins
    logic [2:0] hit_idx;
    always_comb begin
        hit_idx = 3'h0;
        for (int i = NWIN - 1; i >= 0; i--) begin
            if (hit[i]) begin
                hit_idx = 3'(i);
            end
        end
    end
    wire any_hit = |hit;
    wire [AW-1:0] next_axi_addr = (wxlat[hit_idx] & wmask[hit_idx]) |
                                  (req_addr_in & ~wmask[hit_idx]);

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            cfg0 <= CFG0_RST;
            cfg1 <= CFG1_RST;
            for (int i = 0; i < NWIN; i++) begin
                wctrl[i] <= CTRL_RST;
                wbase[i] <= '0;
                wxlat[i] <= '0;
            end
        end else if (reg_wr_in) begin
            if (reg_addr_in == CFG0_OFS) begin
                cfg0 <= reg_wdata_in;
            end
            if (reg_addr_in == CFG1_OFS) begin
                cfg1 <= reg_wdata_in;
            end
            for (int i = 0; i < NWIN; i++) begin
                if (rwin && rwidx == 3'(i)) begin
                    unique case (rword)
                        W_CTRL: wctrl[i] <= reg_wdata_in;
                        W_BLO: wbase[i][31:0] <= reg_wdata_in;
                        W_BHI: wbase[i][63:32] <= reg_wdata_in;
                        W_XLO: wxlat[i][31:0] <= reg_wdata_in;
                        W_XHI: wxlat[i][63:32] <= reg_wdata_in;
                        default: ;
                    endcase
                end
            end
        end
    end

    // Read mux; attribute word reports the effective view
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (reg_addr_in == CFG0_OFS) begin
            next_rdata = cfg0;
        end else if (reg_addr_in == CFG1_OFS) begin
            next_rdata = cfg1;
        end else if (reg_addr_in == STAT_OFS) begin
            next_rdata = {26'h0, last_miss, last_win, dma_rst_out,
                          link_up_in};
        end else if (rwin) begin
            unique case (rword)
                W_CTRL: next_rdata = wctrl[rwidx];
                W_BLO: next_rdata = wbase[rwidx][31:0];
                W_BHI: next_rdata = wbase[rwidx][63:32];
                W_XLO: next_rdata = wxlat[rwidx][31:0];
                W_XHI: next_rdata = wxlat[rwidx][63:32];
                W_ATTR: next_rdata = {21'h0, eff_sz[rwidx][5:0],
                                      eff_en[rwidx], eff_pf[rwidx],
                                      eff64[rwidx], 1'b0, 1'b0};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            reg_rdata_out <= '0;
        end else begin
            reg_rdata_out <= reg_rd_in ? next_rdata : '0;
        end
    end

    // ------------------------------------------------------------
    // Lite routing
    // ------------------------------------------------------------
    wire lite_hi = lite_addr_in[LITE_SEL_BIT];
    assign lite_sel_bridge_out = lite_valid_in && bridge_mode &&
                                 !lite_hi;
    assign lite_sel_dma_out = lite_valid_in && bridge_mode && lite_hi;
    assign lite_sel_intr_out = lite_sel_dma_out &&
                               lite_addr_in[15:12] == INTR_PAGE;

    // ------------------------------------------------------------
    // Request path, link reset and parity
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            axi_valid_out <= 1'b0;
            axi_addr_out <= '0;
            axi_win_out <= '0;
            miss_out <= 1'b0;
            last_win <= '0;
            last_miss <= 1'b0;
            dma_rst_out <= 1'b1;
            wr_par_out <= '0;
            usr_rd_par_out <= '0;
            par_err_out <= 1'b0;
        end else begin
            axi_valid_out <= req_valid_in && any_hit;
            miss_out <= req_valid_in && !any_hit;
            if (req_valid_in && any_hit) begin
                axi_addr_out <= next_axi_addr;
                axi_win_out <= hit_idx;
                last_win <= hit_idx;
            end
            if (req_valid_in) begin
                last_miss <= !any_hit;
            end
            dma_rst_out <= !rst_phy && !link_up_in;
            par_err_out <= par_chk && byte_par(rd_data_in) != rd_par_in;
            usr_rd_par_out <= par_prop ? rd_par_in : '0;
            wr_par_out <= par_chk ? byte_par(wr_data_in) :
                          (par_prop ? usr_wr_par_in : '0);
        end
    end

    // ------------------------------------------------------------
    // DMA and interrupt option outputs
    // ------------------------------------------------------------
    wire [7:0] rd_ch = clamp({5'h0, cfg1[2:0]}, CH_MIN, CH_MAX);
    wire [7:0] wr_ch = clamp({5'h0, cfg1[5:3]}, CH_MIN, CH_MAX);
    assign num_tags_out = !ext_tag ? TAG_BASE :
                          (fam_new ? TAG_NEW : TAG_EXT);
    assign rd_chan_out = rd_ch[2:0];
    assign wr_chan_out = wr_ch[2:0];
    assign rd_outst_out = 7'(clamp({1'b0, cfg1[12:6]}, OUT_MIN,
                                   RD_OUT_MAX));
    assign wr_outst_out = 7'(clamp({2'b00, cfg1[18:13]}, OUT_MIN,
                                   WR_OUT_MAX));
    assign rd_bypass_out = cfg1[22:19] & 4'((5'h01 << rd_ch[2:0]) - 5'h01);
    assign wr_bypass_out = cfg1[26:23] & 4'((5'h01 << wr_ch[2:0]) - 5'h01);
    assign cto_cycles_out = cto_short ? 32'(CTO_SHORT_CYC) :
                            32'(CTO_LONG_CYC);
    assign uirq_cnt_out = 5'(clamp({3'h0, cfg0[19:15]}, UIRQ_MIN,
                                   UIRQ_MAX));
    assign msi_en_out = cfg0[9];
    assign msi_vec_out = 6'(7'h01 << clamp({5'h0, cfg0[12:10]}, 8'h00,
                                            MSI_L2_MAX));
    assign intx_pin_out = 4'h1 << cfg0[14:13];
    assign axi_id_w_out = id_narrow ? ID_W_NARROW : ID_W_WIDE;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    property p_route_lo;
        lite_valid_in && bridge_mode && !lite_addr_in[28] |->
            lite_sel_bridge_out && !lite_sel_dma_out;
    endproperty
    a_route_lo: assert property (p_route_lo)
        else $error("bit 28 low not routed to bridge");

    property p_route_hi;
        lite_valid_in && bridge_mode && lite_addr_in[28] |->
            lite_sel_dma_out && !lite_sel_bridge_out;
    endproperty
    a_route_hi: assert property (p_route_hi)
        else $error("bit 28 high not routed to DMA");

    property p_intr;
        lite_sel_intr_out |-> lite_addr_in[28] &&
            lite_addr_in[15:12] == 4'h2;
    endproperty
    a_intr: assert property (p_intr)
        else $error("interrupt select off offset 0x2000");

    property p_odd;
        wctrl[0][1] |-> !eff_en[1] && !hit[1];
    endproperty
    a_odd: assert property (p_odd)
        else $error("odd window live beside wide window");

    property p_pf;
        !eff64[1] && !eff64[3] && !eff64[5] && !eff_pf[1];
    endproperty
    a_pf: assert property (p_pf)
        else $error("prefetch or wide on odd window");

    property p_xlat;
        req_valid_in && hit[0] ##1 1 |->
            axi_valid_out && axi_win_out == 3'h0 &&
            axi_addr_out == $past(next_axi_addr);
    endproperty
    a_xlat: assert property (p_xlat)
        else $error("translated address wrong");

    property p_miss;
        req_valid_in && hit == '0 |=> miss_out && !axi_valid_out;
    endproperty
    a_miss: assert property (p_miss)
        else $error("miss reached AXI");

    property p_tags;
        !ext_tag |-> num_tags_out == 9'h020;
    endproperty
    a_tags: assert property (p_tags)
        else $error("tag count not 32");

    property p_linkrst;
        !rst_phy && !link_up_in ##1 !rst_phy && !link_up_in |->
            dma_rst_out;
    endproperty
    a_linkrst: assert property (p_linkrst)
        else $error("DMA out of reset with link down");

    property p_cto;
        cto_short |-> cto_cycles_out == 32'd2500;
    endproperty
    a_cto: assert property (p_cto)
        else $error("short timeout count wrong");
endmodule

// File: pdb_pkg.sv
// Constants for the PCIe bridge configuration and address decode block.
// Assumes a 50 MHz system clock and a plain register port.
package pdb_pkg;
    localparam int NWIN = 6;
    localparam int AW = 64;
    localparam int RA_W = 12;
    localparam int CLK_NS = 20;
    // Register map
    localparam logic [11:0] CFG0_OFS = 12'h000;
    localparam logic [11:0] CFG1_OFS = 12'h004;
    localparam logic [11:0] STAT_OFS = 12'h008;
    localparam logic [3:0] WIN_PAGE = 4'h1;
    localparam logic [2:0] W_CTRL = 3'h0;
    localparam logic [2:0] W_BLO = 3'h1;
    localparam logic [2:0] W_BHI = 3'h2;
    localparam logic [2:0] W_XLO = 3'h3;
    localparam logic [2:0] W_XHI = 3'h4;
    localparam logic [2:0] W_ATTR = 3'h5;
    localparam logic [31:0] CFG0_RST = 32'h0008_0200;
    localparam logic [31:0] CFG1_RST = 32'h0004_1009;
    localparam logic [31:0] CTRL_RST = 32'h0000_0060;
    // Lite routing
    localparam int LITE_SEL_BIT = 28;
    localparam logic [3:0] INTR_PAGE = 4'h2;
    // Window limits, as log2 of bytes
    localparam logic [7:0] SZ_MIN = 8'h0c;
    localparam logic [7:0] SZ_MAX32 = 8'h1f;
    localparam logic [7:0] SZ_MAX64 = 8'h26;
    // DMA option limits
    localparam logic [8:0] TAG_BASE = 9'h020;
    localparam logic [8:0] TAG_EXT = 9'h040;
    localparam logic [8:0] TAG_NEW = 9'h100;
    localparam logic [7:0] CH_MIN = 8'h01;
    localparam logic [7:0] CH_MAX = 8'h04;
    localparam logic [7:0] OUT_MIN = 8'h02;
    localparam logic [7:0] RD_OUT_MAX = 8'h40;
    localparam logic [7:0] WR_OUT_MAX = 8'h20;
    localparam logic [7:0] UIRQ_MIN = 8'h01;
    localparam logic [7:0] UIRQ_MAX = 8'h10;
    localparam logic [7:0] MSI_L2_MAX = 8'h05;
    localparam logic [2:0] ID_W_WIDE = 3'h4;
    localparam logic [2:0] ID_W_NARROW = 3'h2;
    // Completion timeout
    localparam longint CTO_LONG_NS = 50000000;
    localparam longint CTO_SHORT_NS = 50000;
    localparam int CTO_SHORT_CYC = int'(CTO_SHORT_NS / CLK_NS);
endpackage

// File: pdb_far_model.sv
// Far-side model: link partner and user logic beside the bridge block.
// Assumes one clock; everything changes just after a rising edge.
`timescale 1ns/1ps
module pdb_far_model (
    input wire logic clk_sys_in, // System clock
    input wire logic rst_in, // Sync reset, high
    input wire logic link_drop_in, // Take the link down
    input wire logic bad_par_in, // Corrupt some read parity
    output logic [31:0] rd_data_out, // Data read from PCIe
    output logic [3:0] rd_par_out, // Its byte parity
    output logic [31:0] wr_data_out, // User data toward PCIe
    output logic [3:0] usr_wr_par_out, // User parity
    output logic link_up_out // Link state
);
    logic [31:0] cnt;

    // Even parity of each byte
    function automatic logic [3:0] byte_par(input logic [31:0] d);
        for (int b = 0; b < 4; b++) begin
            byte_par[b] = ^d[8*b +: 8];
        end
    endfunction

    // Fresh data every cycle so a stale output never matches
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            cnt <= 32'h0000_0000;
            link_up_out <= 1'b1;
        end else begin
            cnt <= cnt + 32'h9E37_79B9;
            link_up_out <= !link_drop_in;
        end
    end

    assign rd_data_out = cnt;
    // link data with parity, bad on odd counts when asked
    assign rd_par_out = byte_par(cnt) ^ {3'h0, bad_par_in & cnt[0]};
    assign wr_data_out = {cnt[15:0], ~cnt[31:16]};
    // user logic makes its own parity
    assign usr_wr_par_out = byte_par(wr_data_out);
endmodule

// File: pdb_bridge_cfg_tb.sv
// Self-checking bench for the bridge configuration and decode block.
// Assumes the far-side model supplies link data, parity and link state.
`timescale 1ns/1ps
module pdb_bridge_cfg_tb;
    import pdb_pkg::*;
    typedef struct {logic [63:0] a; logic h; logic [2:0] w;
        logic [63:0] x;} pdb_req_type;
    typedef struct {logic [31:0] c0, c1, cto; logic [8:0] tg;
        logic [2:0] rc, wc, iw; logic [6:0] ro, wo; logic [3:0] rb, wb, ix;
        logic [4:0] ui; logic me; logic [5:0] mv;} pdb_opt_type;
    logic clk_sys_in = 1'b0, rst_in = 1'b1;
    logic [11:0] reg_addr_in = 12'h000;
    logic [31:0] reg_wdata_in = 32'h0000_0000, lite_addr_in = 32'h0000_0000;
    logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, lite_valid_in = 1'b0;
    logic req_valid_in = 1'b0, link_drop = 1'b0, bad_par = 1'b1;
    logic [63:0] req_addr_in = 64'h0000_0000_0000_0000;
    logic [31:0] reg_rdata_out, rd_data_in, wr_data_in, cto_cycles_out;
    logic lite_sel_bridge_out, lite_sel_dma_out, lite_sel_intr_out;
    logic axi_valid_out, miss_out, link_up_in, dma_rst_out, par_err_out;
    logic [63:0] axi_addr_out;
    logic [2:0] axi_win_out, rd_chan_out, wr_chan_out, axi_id_w_out;
    logic [3:0] rd_par_in, usr_wr_par_in, wr_par_out, usr_rd_par_out;
    logic [3:0] rd_bypass_out, wr_bypass_out, intx_pin_out;
    logic [8:0] num_tags_out;
    logic [6:0] rd_outst_out, wr_outst_out;
    logic [4:0] uirq_cnt_out;
    logic msi_en_out;
    logic [5:0] msi_vec_out;
    int bad_count = 0, comparisons = 0;
    logic [31:0] lite_a [6] = '{32'h0000_2000, 32'h1000_2000, 32'h1000_2FFC,
        32'h1000_1000, 32'h0FFF_FFFF, 32'hF000_3000};
    logic [2:0] lite_e [6] = '{3'h4, 3'h3, 3'h3, 3'h2, 3'h4, 3'h2};
    pdb_req_type reqs [12] = '{
        '{64'h40_0001_2345, 1'h1, 3'h0, 64'hA001_2345},
        '{64'h40_0010_0000, 1'h0, 3'h0, 64'h0},
        '{64'h9234_5678, 1'h1, 3'h2, 64'h1_1234_5678},
        '{64'h1_9234_5678, 1'h0, 3'h0, 64'h0},
        '{64'h3FFF, 1'h1, 3'h3, 64'h5_0FFF},
        '{64'h4000, 1'h0, 3'h0, 64'h0},
        '{64'h2FFF, 1'h0, 3'h0, 64'h0},
        '{64'h3000, 1'h1, 3'h3, 64'h5_0000},
        '{64'h0123, 1'h0, 3'h0, 64'h0},
        '{64'h3000, 1'h0, 3'h0, 64'h0},
        '{64'h40_0000_0000, 1'h1, 3'h0, 64'hA000_0000},
        '{64'h9234_5678, 1'h0, 3'h0, 64'h0}};
    pdb_opt_type opts [3] = '{
        '{CFG0_RST, CFG1_RST, 32'h64, 9'h020, 3'h1, 3'h1, 3'h4, 7'h40, 7'h20,
            4'h0, 4'h0, 4'h1, 5'h10, 1'h1, 6'h01},
        '{32'h0000_76C5, 32'h07FF_E057, 32'h09C4, 9'h040, 3'h4, 3'h2, 3'h2,
            7'h02, 7'h20, 4'hF, 4'h3, 4'h8, 5'h01, 1'h1, 6'h20},
        '{32'h000F_A00C, 32'h02D0_3FE0, 32'h64, 9'h100, 3'h1, 3'h4, 3'h4,
            7'h40, 7'h02, 4'h0, 4'h5, 4'h2, 5'h10, 1'h0, 6'h01}};

    // Design and far side
    pdb_bridge_cfg #(.DW(32), .CTO_LONG_CYC(100)) u_dut (.*);
    pdb_far_model u_far (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .link_drop_in(link_drop), .bad_par_in(bad_par),
        .rd_data_out(rd_data_in), .rd_par_out(rd_par_in),
        .wr_data_out(wr_data_in), .usr_wr_par_out(usr_wr_par_in),
        .link_up_out(link_up_in));

    // 50 MHz clock
    always #(CLK_NS / 2) clk_sys_in = ~clk_sys_in;

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string n, input logic [63:0] e,
        input logic [63:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    function automatic logic [3:0] bpar(input logic [31:0] d);
        for (int b = 0; b < 4; b++) begin
            bpar[b] = ^d[8*b +: 8];
        end
    endfunction
    function automatic logic [11:0] wa(input logic [2:0] i,
        input logic [2:0] w);
        return {WIN_PAGE, i, w, 2'h0};
    endfunction
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rdchk(input string n, input logic [11:0] a,
        input logic [31:0] m, input logic [31:0] e);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1;
        chk(n, e, reg_rdata_out & m);
    endtask
    task automatic run_reqs(input int first, input int last);
        for (int i = first; i <= last + 1; i++) begin
            @(posedge clk_sys_in);
            req_valid_in <= (i <= last);
            req_addr_in <= reqs[(i > last) ? last : i].a;
            #1;
            if (i > first) begin
                chk("axi_valid", reqs[i-1].h, axi_valid_out);
                chk("miss", !reqs[i-1].h, miss_out);
                if (reqs[i-1].h) begin
                    chk("axi_addr", reqs[i-1].x, axi_addr_out);
                    chk("axi_win", reqs[i-1].w, axi_win_out);
                end
            end
        end
    endtask
    task automatic link_step(input logic drop, input logic e);
        @(posedge clk_sys_in);
        link_drop <= drop;
        repeat (3) @(posedge clk_sys_in);
        #1;
        chk("dma_rst", e, dma_rst_out);
    endtask
    task automatic par_run(input logic ck, input logic pp);
        logic [31:0] prd, pwr;
        logic [3:0] prp, pup;
        for (int k = 0; k < 8; k++) begin
            @(posedge clk_sys_in);
            #1;
            if (k > 0) begin
                chk("par_err", ck && prp !== bpar(prd), par_err_out);
                if (ck) chk("wr_par", bpar(pwr), wr_par_out);
                if (pp && !ck) chk("wr_par_p", pup, wr_par_out);
                if (!ck && !pp) chk("wr_par_off", 4'h0, wr_par_out);
                chk("usr_rd_par", pp ? prp : 4'h0, usr_rd_par_out);
            end
            prd = rd_data_in;
            prp = rd_par_in;
            pwr = wr_data_in;
            pup = usr_wr_par_in;
        end
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        #1;
        chk("dma_rst_reset", 1'b1, dma_rst_out);
        rdchk("cfg0", CFG0_OFS, 32'hFFFF_FFFF, CFG0_RST);
        rdchk("win_ctrl", wa(3'h0, W_CTRL), 32'hFFFF_FFFF, CTRL_RST);
        rdchk("unmapped", 12'hFFC, 32'hFFFF_FFFF, 32'h0);
        // Option rows: reset values, then two settings with clamping
        for (int i = 0; i < 3; i++) begin
            if (i > 0) begin
                wr(CFG0_OFS, opts[i].c0);
                wr(CFG1_OFS, opts[i].c1);
            end
            @(posedge clk_sys_in);
            #1;
            chk("tags", opts[i].tg, num_tags_out);
            chk("rd_chan", opts[i].rc, rd_chan_out);
            chk("wr_chan", opts[i].wc, wr_chan_out);
            chk("rd_outst", opts[i].ro, rd_outst_out);
            chk("wr_outst", opts[i].wo, wr_outst_out);
            chk("rd_bypass", opts[i].rb, rd_bypass_out);
            chk("wr_bypass", opts[i].wb, wr_bypass_out);
            chk("cto", opts[i].cto, cto_cycles_out);
            chk("uirq", opts[i].ui, uirq_cnt_out);
            chk("msi_en", opts[i].me, msi_en_out);
            if (opts[i].me) chk("msi_vec", opts[i].mv, msi_vec_out);
            chk("intx", opts[i].ix, intx_pin_out);
            chk("id_w", opts[i].iw, axi_id_w_out);
        end
        $display("test options done");
        wr(CFG0_OFS, 32'h0008_0201);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_sys_in);
            lite_valid_in <= 1'b1;
            lite_addr_in <= lite_a[i];
            #1;
            chk("lite_sel", lite_e[i], {lite_sel_bridge_out,
                lite_sel_dma_out, lite_sel_intr_out});
        end
        wr(CFG0_OFS, CFG0_RST);
        #1;
        chk("lite_off", 3'h0, {lite_sel_bridge_out, lite_sel_dma_out,
            lite_sel_intr_out});
        wr(CFG0_OFS, 32'h0008_0201);
        $display("test lite routing done");
        wr(wa(3'h0, W_BHI), 32'h0000_0040);
        wr(wa(3'h0, W_XLO), 32'hA000_0000);
        wr(wa(3'h0, W_CTRL), 32'h0000_00A7);
        wr(wa(3'h1, W_CTRL), 32'h0000_0061);
        wr(wa(3'h2, W_BLO), 32'h8000_0000);
        wr(wa(3'h2, W_XHI), 32'h0000_0001);
        wr(wa(3'h2, W_CTRL), 32'h0000_0145);
        wr(wa(3'h3, W_BLO), 32'h0000_3000);
        wr(wa(3'h3, W_XLO), 32'h0005_0000);
        wr(wa(3'h3, W_CTRL), 32'h0000_0029);
        rdchk("attr0", wa(3'h0, W_ATTR), 32'h7FF, 32'h29C);
        rdchk("attr1", wa(3'h1, W_ATTR), 32'h10, 32'h0);
        rdchk("attr2", wa(3'h2, W_ATTR), 32'h7FF, 32'h3F0);
        rdchk("attr3", wa(3'h3, W_ATTR), 32'h7FF, 32'h190);
        run_reqs(0, 8);
        wr(CFG0_OFS, 32'h0008_0203);
        rdchk("attr2_root", wa(3'h2, W_ATTR), 32'h10, 32'h0);
        run_reqs(9, 11);
        wr(CFG0_OFS, 32'h0008_0201);
        $display("test windows done");
        link_step(1'b1, 1'b1);
        rdchk("status", STAT_OFS, 32'h3F, 32'h22);
        link_step(1'b0, 1'b0);
        wr(CFG0_OFS, 32'h0008_0301);
        link_step(1'b1, 1'b0);
        link_step(1'b0, 1'b0);
        $display("test link reset done");
        wr(CFG0_OFS, 32'h0008_0210);
        par_run(1'b1, 1'b0);
        wr(CFG0_OFS, 32'h0008_0220);
        par_run(1'b0, 1'b1);
        wr(CFG0_OFS, CFG0_RST);
        par_run(1'b0, 1'b0);
        $display("test parity done");
        // Reset again mid-run
        rst_in <= 1'b1;
        @(posedge clk_sys_in);
        rst_in <= 1'b0;
        #1;
        chk("dma_rst_again", 1'b1, dma_rst_out);
        rdchk("cfg1_again", CFG1_OFS, 32'hFFFF_FFFF, CFG1_RST);
        $display("test reset done");
        end_sim();
    end

    // Cut a hang short
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        bad_count++;
        end_sim();
    end
endmodule
